// ===== hdl/rtcits_pkg.sv
// constants and types for the rtc interrupt timer and status block
package rtcits_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [3:0] ADDR_CTL   = 4'h0;
  localparam logic [3:0] ADDR_TIME0 = 4'h1;
  localparam logic [3:0] ADDR_DLY   = 4'hf;

  localparam int CTL_INT_STOP = 0;
  localparam int CTL_INT_SEL  = 1;
  localparam int CTL_CLK_STOP = 2;
  localparam int CTL_TEST     = 3;
  localparam int STS_INTF     = 0;
  localparam int STS_DCF      = 3;
  localparam int DLY_REPEAT   = 3;

  localparam logic [3:0]  CTL_RESET  = 4'h1;
  localparam logic [3:0]  DLY_RESET  = 4'h0;
  localparam logic [3:0]  CSR_RESET  = 4'h0;
  localparam logic [10:0] PIN_IDLE   = 11'h7ff;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int TICK_MS       = 1;
  localparam int CYC_PER_MS    = CLK_HZ / 1000 * TICK_MS;
  localparam int SET_PERIOD_MS = 100;
  localparam int MS_PER_SET    = SET_PERIOD_MS / TICK_MS;
  localparam int CTL_RD_MAX_MS = 30;

  // ***************************************************
  // time digits, lowest first: tenths, sec units, sec tens, min units, min tens
  // ***************************************************
  localparam int          TIME_DIGITS = 5;
  localparam logic [19:0] DIGIT_MAX   = 20'h59599;

  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} rtcits_bus_t;

  // delay code to milliseconds; all multiples of the setting period
  function automatic logic [15:0] rtcits_delay_ms(input logic [2:0] code);
    logic [15:0] ms;
    case (code)
      3'h1:    ms = 16'h0064;
      3'h2:    ms = 16'h01f4;
      3'h3:    ms = 16'h03e8;
      3'h4:    ms = 16'h1388;
      3'h5:    ms = 16'h2710;
      3'h6:    ms = 16'h7530;
      3'h7:    ms = 16'hea60;
      default: ms = 16'h0000;
    endcase
    return ms;
  endfunction

endpackage

// ===== hdl/rtcits_time_chain.sv
// ripple counter chain of bcd time digits
`timescale 1ns/1ps
module rtcits_time_chain
  import rtcits_pkg::*;
#(
  parameter int DIGITS = TIME_DIGITS
)
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  input  wire logic                  i_step,
  input  wire logic                  i_clear_low,
  output logic      [DIGITS*4-1:0]   o_digits
);

  logic [DIGITS:0] carry;

  assign carry[0] = i_step;

  // ***************************************************
  // one bcd digit per stage, carry only on wrap
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < DIGITS; g = g + 1)
    begin : g_digit
      logic [3:0] digit;
      logic [3:0] next_digit;

      assign carry[g+1] = carry[g] && (digit == DIGIT_MAX[g*4 +: 4]);

      always_comb
      begin
        next_digit = digit;
        if (g == 0 && i_clear_low)
          next_digit = 4'h0;
        else if (carry[g])
          next_digit = (digit == DIGIT_MAX[g*4 +: 4]) ? 4'h0 : digit + 4'h1;
      end

      always_ff @(posedge i_mclk)
      begin
        if (i_srst)
          digit <= 4'h0;
        else
          digit <= next_digit;
      end

      assign o_digits[g*4 +: 4] = digit;
    end
  endgenerate

endmodule

// ===== hdl/rtcits_top.sv
// rtc status flags, interrupt timer and host register port
`timescale 1ns/1ps
module rtcits_top
  import rtcits_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [3:0]  i_data,
  output logic      [3:0]  o_data,
  output logic             o_data_oe_n,
  output logic             o_int,
  output logic             o_int_oe_n
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [10:0] pin_raw;
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic [10:0] sync3;
  logic [10:0] pins;
  logic [10:0] next_pins;

  assign pin_raw = {i_cs_n, i_rd_n, i_wr_n, i_addr, i_data};

  // a bit moves only once the last two stages agree
  genvar b;
  generate
    for (b = 0; b < 11; b = b + 1)
    begin : g_filt
      assign next_pins[b] = (sync2[b] == sync3[b]) ? sync3[b] : pins[b];
    end
  endgenerate

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      pins  <= PIN_IDLE;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pins  <= next_pins;
    end
  end

  logic       cs;
  logic       rd;
  logic       wr;
  logic [3:0] addr;
  logic [3:0] din;

  // chip select alone can frame the access once rd/wr are settled
  assign cs   = ~pins[10];
  assign rd   = ~pins[9];
  assign wr   = ~pins[8];
  assign addr = pins[7:4];
  assign din  = pins[3:0];

  // ***************************************************
  // bus phase and read data
  // ***************************************************
  rtcits_bus_t bus;
  rtcits_bus_t next_bus;
  logic [3:0]  rd_addr;
  logic [3:0]  next_rd_addr;
  logic [3:0]  next_data;
  logic [3:0]  rd_val;
  logic [3:0]  ctl;
  logic [3:0]  dly;
  logic [3:0]  csr;
  logic        dcf;
  logic        intf;
  logic [TIME_DIGITS*4-1:0] digits;

  logic rd_start;
  logic wr_pulse;
  logic rd_hold;
  logic rd_end;

  assign rd_start = (bus == BUS_IDLE) && cs && rd;
  assign wr_pulse = (bus == BUS_IDLE) && cs && wr && !rd;
  assign rd_hold  = (bus == BUS_READ) && (rd_addr == ADDR_CTL);
  assign rd_end   = rd_hold && !(cs && rd);

  always_comb
  begin
    rd_val = 4'h0;
    if (addr == ADDR_CTL)
    begin
      rd_val[STS_DCF]  = dcf;
      rd_val[STS_INTF] = intf;
    end
    else if (addr == ADDR_DLY)
      rd_val = ctl[CTL_INT_SEL] ? dly : csr;
    else
      for (int k = 0; k < TIME_DIGITS; k++)
        if (addr == ADDR_TIME0 + 4'(k))
          rd_val = digits[k*4 +: 4];
  end

  always_comb
  begin
    next_bus     = bus;
    next_rd_addr = rd_addr;
    next_data    = o_data;
    case (bus)
      BUS_IDLE:
      begin
        if (cs && rd)
        begin
          next_bus     = BUS_READ;
          next_rd_addr = addr;
          next_data    = rd_val;
        end
        else if (cs && wr)
          next_bus = BUS_WRITE;
      end
      BUS_READ:
        if (!(cs && rd))
          next_bus = BUS_IDLE;
      BUS_WRITE:
        if (!(cs && wr))
          next_bus = BUS_IDLE;
      default:
        next_bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      bus     <= BUS_IDLE;
      rd_addr <= ADDR_CTL;
      o_data  <= 4'h0;
    end
    else
    begin
      bus     <= next_bus;
      rd_addr <= next_rd_addr;
      o_data  <= next_data;
    end
  end

  assign o_data_oe_n = (bus != BUS_READ);

  // ***************************************************
  // millisecond prescaler and setting pulse
  // ***************************************************
  logic [15:0] pre;
  logic [15:0] next_pre;
  logic [6:0]  ms_cnt;
  logic [6:0]  next_ms_cnt;
  logic        ms_tick;
  logic        set_pulse;

  // prescaler is free running so repeated timeouts keep a fixed phase
  assign ms_tick   = (pre == 16'(CYCLES_PER_MS - 1));
  assign set_pulse = ms_tick && (ms_cnt == 7'(MS_PER_SET - 1)) && !ctl[CTL_CLK_STOP];

  always_comb
  begin
    next_pre    = ms_tick ? 16'h0 : pre + 16'h1;
    next_ms_cnt = ms_cnt;
    if (ctl[CTL_CLK_STOP])
      next_ms_cnt = 7'h0;
    else if (ms_tick)
      next_ms_cnt = (ms_cnt == 7'(MS_PER_SET - 1)) ? 7'h0 : ms_cnt + 7'h1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pre    <= 16'h0;
      ms_cnt <= 7'h0;
    end
    else
    begin
      pre    <= next_pre;
      ms_cnt <= next_ms_cnt;
    end
  end

  rtcits_time_chain #(
    .DIGITS      (TIME_DIGITS)
  ) u_chain (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_step      (set_pulse),
    .i_clear_low (ctl[CTL_CLK_STOP]),
    .o_digits    (digits)
  );

  // ***************************************************
  // registers and interrupt timer
  // ***************************************************
  logic        wr_ctl;
  logic        wr_dly;
  logic        tmr_start;
  logic        tmr_stop;
  logic        timeout;
  logic        run;
  logic        run_rep;
  logic [15:0] run_len;
  logic [15:0] cnt;
  logic        pend;
  logic [3:0]  next_ctl;
  logic [3:0]  next_dly;
  logic [3:0]  next_csr;
  logic        next_run;
  logic        next_run_rep;
  logic [15:0] next_run_len;
  logic [15:0] next_cnt;
  logic        next_pend;
  logic        next_dcf;
  logic        next_intf;

  assign wr_ctl    = wr_pulse && (addr == ADDR_CTL);
  assign wr_dly    = wr_pulse && (addr == ADDR_DLY) && ctl[CTL_INT_SEL];
  assign tmr_start = wr_ctl && !din[CTL_INT_STOP];
  // an empty delay word also halts the timer
  assign tmr_stop  = (wr_ctl && din[CTL_INT_STOP]) || (wr_dly && din == 4'h0);
  assign timeout   = run && ms_tick && (cnt == 16'h0);

  always_comb
  begin
    next_ctl     = ctl;
    next_dly     = dly;
    next_csr     = csr;
    next_run     = run;
    next_run_rep = run_rep;
    next_run_len = run_len;
    next_cnt     = cnt;
    next_pend    = pend;
    next_dcf     = dcf;
    next_intf    = intf;
    if (wr_ctl)
      next_ctl = din;
    if (wr_dly)
    begin
      next_dly = din;
      if (din == 4'h0)
        next_ctl[CTL_INT_STOP] = 1'b1;
    end
    if (wr_pulse && addr == ADDR_DLY && !ctl[CTL_INT_SEL])
      next_csr = din;
    // delay word is sampled only here, on a start write; a repeat reload reuses run_len
    if (tmr_stop)
      next_run = 1'b0;
    else if (tmr_start)
    begin
      next_run_len = rtcits_delay_ms(dly[2:0]);
      next_run_rep = dly[DLY_REPEAT];
      next_run     = (dly[2:0] != 3'h0);
      next_cnt     = rtcits_delay_ms(dly[2:0]) - 16'h1;
    end
    else if (run && ms_tick)
    begin
      if (cnt != 16'h0)
        next_cnt = cnt - 16'h1;
      else if (run_rep)
        next_cnt = run_len - 16'h1;
      else
        next_run = 1'b0;
    end
    // flags are frozen while a control read is open
    if (rd_hold)
    begin
      if (timeout)
        next_pend = 1'b1;
      if (rd_end)
      begin
        next_intf = pend || timeout;
        next_pend = 1'b0;
        next_dcf  = 1'b0;
      end
    end
    else
    begin
      if (timeout)
        next_intf = 1'b1;
      if (set_pulse)
        next_dcf = 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      ctl     <= CTL_RESET;
      dly     <= DLY_RESET;
      csr     <= CSR_RESET;
      run     <= 1'b0;
      run_rep <= 1'b0;
      run_len <= 16'h0;
      cnt     <= 16'h0;
      pend    <= 1'b0;
      dcf     <= 1'b0;
      intf    <= 1'b0;
    end
    else
    begin
      ctl     <= next_ctl;
      dly     <= next_dly;
      csr     <= next_csr;
      run     <= next_run;
      run_rep <= next_run_rep;
      run_len <= next_run_len;
      cnt     <= next_cnt;
      pend    <= next_pend;
      dcf     <= next_dcf;
      intf    <= next_intf;
    end
  end

  // open drain: pulled low while the flag stands
  assign o_int      = 1'b0;
  assign o_int_oe_n = ~intf;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  sequence s_ctl_read_open;
    rd_hold && !rd_end;
  endsequence

  sequence s_ctl_read_close;
    rd_end && !pend && !timeout;
  endsequence

  a_dcf_sets: assert property (set_pulse && !rd_hold |=> dcf && (addr != ADDR_CTL || rd_val[STS_DCF]))
    else $error("time changed flag not set by setting pulse");
  a_dcf_clears: assert property (rd_end |=> !dcf)
    else $error("time changed flag not cleared by control read");
  a_intf_sets: assert property (timeout && !rd_hold |=> intf && !o_int_oe_n)
    else $error("timeout did not raise interrupt");
  a_read_holds: assert property (s_ctl_read_open |=> intf == $past(intf) && dcf == $past(dcf))
    else $error("flags moved during control read");
  a_int_release: assert property (s_ctl_read_close |=> o_int_oe_n && !intf)
    else $error("interrupt not released after control read");
  a_pend_stored: assert property (rd_hold && timeout |=> pend || intf)
    else $error("timeout during control read not stored");
  a_pend_delivered: assert property (rd_end && pend |=> intf && !o_int_oe_n)
    else $error("timeout during control read lost");
  a_single_stops: assert property (timeout && !run_rep && !tmr_start |=> !run)
    else $error("single mode timer kept running");
  a_repeat_reload: assert property (timeout && run_rep && !tmr_stop && !tmr_start |=> run && cnt == run_len - 16'h1)
    else $error("repeated timer did not reload");
  a_stop_write: assert property (tmr_stop |=> !run ##1 !timeout)
    else $error("stop write did not halt timer");
  a_start_len: assert property (tmr_start && dly[2:0] != 3'h0 |=> run && cnt == rtcits_delay_ms($past(dly[2:0])) - 16'h1)
    else $error("start write did not load full delay");
  a_dly_load: assert property (wr_dly |=> dly == $past(din))
    else $error("delay register not loaded");
  a_time_read: assert property (rd_start && addr != ADDR_CTL && !set_pulse && !rd_hold |=> dcf == $past(dcf))
    else $error("time read disturbed flag");

endmodule

// ===== tb/rtcits_host.sv
// host processor model driving the register pins
`timescale 1ns/1ps
module rtcits_host
(
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_rd_data,
  input  wire logic       i_oe_n,
  input  wire logic       i_int_n,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [3:0] o_addr,
  output logic      [3:0] o_data
);
  initial
  begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 4'h0;
    o_data = 4'h0;
  end

  // hold stretches the strobe; callers keep it far below 30 ms
  task automatic rd(input logic [3:0] a, input int hold, output logic [3:0] d,
                    output logic ok, output logic il);
    ok = 1'b0;
    il = 1'b0;
    d = 4'h0;
    @(posedge i_mclk);
    o_addr <= a;
    o_rd_n <= 1'b0;
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge i_mclk);
      ok = (i_oe_n === 1'b0);
      d = i_rd_data;
    end
    for (int n = 0; n < hold; n++)
    begin
      @(posedge i_mclk);
      il |= (i_int_n === 1'b0);
    end
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    o_addr <= ~a;
    for (int n = 0; n < 20 && i_oe_n !== 1'b1; n++)
      @(posedge i_mclk);
    ok &= (i_oe_n === 1'b1);
    repeat (6) @(posedge i_mclk);
  endtask

  // released lines show the inverse, never a stale value
  task automatic wr(input logic [3:0] a, input logic [3:0] v);
    @(posedge i_mclk);
    o_addr <= a;
    o_data <= v;
    o_wr_n <= 1'b0;
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    repeat (8) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_data <= ~v;
    o_addr <= ~a;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule

// ===== tb/test_rtc_interrupt_timer_status.sv
// self-checking bench for the rtc status flags and interrupt timer
`timescale 1ns/1ps
module test_rtc_interrupt_timer_status;
  import rtcits_pkg::*;
  // short ms keeps the run small
  localparam int CPM = 4;
  localparam int PER = 100 * CPM;
  logic       i_mclk;
  logic       i_srst;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [3:0] addr;
  logic [3:0] wdat;
  logic [3:0] rdat;
  logic       oe_n;
  logic       int_v;
  logic       int_oe_n;
  wire        int_n = int_oe_n ? 1'b1 : int_v;
  int         cyc = 0;
  int         fail_count = 0;
  int         n_compared = 0;

  rtcits_top #(.CYCLES_PER_MS(CPM)) u_dut
  (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .i_data(wdat), .o_data(rdat), .o_data_oe_n(oe_n),
    .o_int(int_v), .o_int_oe_n(int_oe_n)
  );
  // released data lines show the inverse, so a stale value cannot pass
  rtcits_host u_host
  (
    .i_mclk(i_mclk), .i_rd_data(oe_n ? ~rdat : rdat), .i_oe_n(oe_n), .i_int_n(int_n),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(wdat)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk)
    cyc <= cyc + 1;

  // ****
  // checks and bus helpers
  // ****
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic bad(input string m);
    fail_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp)
      bad($sformatf("got %h expected %h", got, exp));
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
      bad($sformatf("count %0d outside %0d..%0d", got, lo, hi));
  endtask

  // negative hold picks a random short strobe
  task automatic rdc(input logic [3:0] a, input int hold, output logic [3:0] d, output logic il);
    logic ok;
    u_host.rd(a, hold < 0 ? int'($urandom_range(3)) : hold, d, ok, il);
    if (ok !== 1'b1)
    begin
      bad("no read answer");
      conclude();
    end
  endtask

  task automatic wait_int(input int bound, output int t);
    for (int n = 0; n < bound && int_n !== 1'b0; n++)
      @(posedge i_mclk);
    t = cyc;
    if (int_n !== 1'b0)
    begin
      bad("no interrupt");
      conclude();
    end
  endtask

  task automatic quiet(input int len);
    logic seen;
    seen = 1'b0;
    repeat (len)
    begin
      @(posedge i_mclk);
      seen |= (int_n === 1'b0);
    end
    chk({3'h0, seen}, 4'h0);
  endtask

  initial
  begin
    logic [3:0] d;
    logic       il;
    int         t0;
    int         t1;
    int         t2;
    int         a;
    void'($urandom(32'h3ddb0077));
    i_srst = 1'b1;
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (6) @(posedge i_mclk);
    rdc(ADDR_CTL, -1, d, il);
    chk(d, 4'h0);
    rdc(ADDR_DLY, -1, d, il);
    chk(d, CSR_RESET);
    for (int k = 0; k < 4; k++)
    begin
      a = 6 + $urandom_range(8);
      u_host.wr(4'(a), 4'($urandom));
      rdc(4'(a), -1, d, il);
      chk(d, 4'h0);
    end
    // poll lands just after a setting pulse, so 100 ms stay free
    // a pulse inside an open control read is dropped, so allow several pulses
    for (int k = 0; k < 80 && d[STS_DCF] !== 1'b1; k++)
      rdc(ADDR_CTL, -1, d, il);
    chk(d, 4'h8);
    rdc(ADDR_CTL, -1, d, il);
    chk(d, 4'h0);
    a = $urandom_range(4);
    for (int k = 0; k < 5; k++)
      rdc(4'(1 + (k * 3 + a) % 5), -1, d, il);
    rdc(ADDR_CTL, -1, d, il);
    chk(d, 4'h0);
    repeat (PER + 20) @(posedge i_mclk);
    rdc(ADDR_TIME0, -1, d, il);
    rdc(ADDR_CTL, -1, d, il);
    chk(d, 4'h8);
    // host rereads the block until no setting pulse lands inside it
    for (int k = 0; k < 4 && d[STS_DCF] === 1'b1; k++)
    begin
      rdc(ADDR_TIME0, -1, d, il);
      rdc(ADDR_CTL, -1, d, il);
    end
    chk(d, 4'h0);
    u_host.wr(ADDR_CTL, 4'h3);
    u_host.wr(ADDR_DLY, 4'h1);
    rdc(ADDR_DLY, -1, d, il);
    chk(d, 4'h1);
    t0 = cyc;
    u_host.wr(ADDR_CTL, 4'h2);
    wait_int(PER + 60, t1);
    chk_rng(t1 - t0, PER - CPM, PER + 3 * CPM);
    rdc(ADDR_CTL, -1, d, il);
    chk({3'h0, d[STS_INTF]}, 4'h1);
    chk({3'h0, int_n}, 4'h1);
    rdc(ADDR_CTL, -1, d, il);
    chk({3'h0, d[STS_INTF]}, 4'h0);
    quiet(PER + 40);
    u_host.wr(ADDR_DLY, 4'h2);
    t0 = cyc;
    u_host.wr(ADDR_CTL, 4'h0);
    u_host.wr(ADDR_DLY, 4'h5);
    rdc(ADDR_DLY, -1, d, il);
    chk(d, 4'h5);
    wait_int(5 * PER + 60, t1);
    chk_rng(t1 - t0, 5 * PER - CPM, 5 * PER + 3 * CPM);
    rdc(ADDR_CTL, -1, d, il);
    u_host.wr(ADDR_CTL, 4'h3);
    u_host.wr(ADDR_DLY, 4'h9);
    u_host.wr(ADDR_CTL, 4'h2);
    wait_int(PER + 60, t1);
    rdc(ADDR_CTL, -1, d, il);
    wait_int(PER, t2);
    chk_rng(t2 - t1, PER, PER);
    rdc(ADDR_CTL, -1, d, il);
    // long control read spanning the next timeout
    repeat (t2 + PER - 20 - cyc) @(posedge i_mclk);
    rdc(ADDR_CTL, 50, d, il);
    chk({2'h0, il, d[STS_INTF]}, 4'h0);
    wait_int(20, t1);
    rdc(ADDR_CTL, -1, d, il);
    chk({3'h0, d[STS_INTF]}, 4'h1);
    u_host.wr(ADDR_CTL, 4'h1);
    quiet(PER + 40);
    t0 = cyc;
    u_host.wr(ADDR_CTL, 4'h2);
    wait_int(PER + 60, t1);
    chk_rng(t1 - t0, PER - CPM, PER + 3 * CPM);
    rdc(ADDR_CTL, -1, d, il);
    u_host.wr(ADDR_CTL, 4'h3);
    quiet(PER + 40);
    // clock stop: no setting pulses, tenths held at zero
    u_host.wr(ADDR_CTL, 4'h5);
    rdc(ADDR_CTL, -1, d, il);
    repeat (PER + 20) @(posedge i_mclk);
    rdc(ADDR_TIME0, -1, d, il);
    chk(d, 4'h0);
    rdc(ADDR_CTL, -1, d, il);
    chk(d, 4'h0);
    conclude();
  end
endmodule
